// [inc/spsc_pkg.sv]
package spsc_pkg;
   // encoded power state driving every pin group except the resume well inputs and usb port enables
   typedef enum logic [2:0] {
      SPSC_RESET,
      SPSC_RUN,
      SPSC_POS,
      SPSC_RAM,
      SPSC_DISK
   } spsc_state_e;
   // pin states after reset of the resume well
   localparam logic SPSC_GPIO_RST_OUT = 1'b0;
   localparam logic SPSC_GPIO_RST_OE = 1'b0;
   // suspend clock divider, half period in cycles
   localparam int SPSC_SUS_CLOCK_HALF = 4;
   // bus clock divider, half period in cycles
   localparam int SPSC_BUSCLK_HALF = 2;
   localparam int SPSC_DIV_W = 8;
endpackage

// [hdl/spsc_clkdiv.sv]
`timescale 1ns/100ps
// free-running clock divider with a run gate; output held low when stopped
module spsc_clkdiv #(
   parameter int HALF = 4
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic run,
   output logic clk_out
);
   logic [spsc_pkg::SPSC_DIV_W-1:0] cnt_q, cnt_d; // half-period counter
   logic lvl_q, lvl_d; // output level

   // next-state: toggle at terminal count, park low when stopped
   always_comb
   begin
      cnt_d = cnt_q;
      lvl_d = lvl_q;
      if (!run)
      begin
         cnt_d = '0;
         lvl_d = 1'b0;
      end
      else if (cnt_q == spsc_pkg::SPSC_DIV_W'(HALF - 1))
      begin
         cnt_d = '0;
         lvl_d = ~lvl_q;
      end
      else
         cnt_d = cnt_q + 1'b1;
   end

   // registers, frozen by clock enable
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_q <= '0;
         lvl_q <= 1'b0;
      end
      else if (ce)
      begin
         cnt_q <= cnt_d;
         lvl_q <= lvl_d;
      end
   end

   assign clk_out = lvl_q;
endmodule // spsc_clkdiv

// [hdl/spsc_gpio_hold.sv]
`timescale 1ns/100ps
// resume-well gpio pin state: functional on resume reset, kept on bus reset
module spsc_gpio_hold (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic gpio_mode,
   input wire logic gpio_out,
   input wire logic gpio_oe,
   output logic pin_out,
   output logic pin_oe,
   output logic pin_gpio
);
   logic out_q, out_d; // last gpio drive level
   logic oe_q, oe_d; // last gpio enable
   logic mode_q, mode_d; // pin is in gpio mode

   // next-state: follow software while powered, nothing else clears it
   always_comb
   begin
      out_d = gpio_out;
      oe_d = gpio_oe;
      mode_d = gpio_mode;
   end

   // only resume reset lands here; bus reset never reaches this flop
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         out_q <= spsc_pkg::SPSC_GPIO_RST_OUT;
         oe_q <= spsc_pkg::SPSC_GPIO_RST_OE;
         mode_q <= 1'b0;
      end
      else if (ce)
      begin
         out_q <= out_d;
         oe_q <= oe_d;
         mode_q <= mode_d;
      end
   end

   assign pin_out = out_q;
   assign pin_oe = oe_q & mode_q;
   assign pin_gpio = mode_q;
endmodule // spsc_gpio_hold

// [hdl/spsc_top.sv]
`timescale 1ns/100ps
module spsc_top #(
   parameter int ACK_W = 4,
   parameter int OVC_W = 2
) (
   input wire logic CLK,
   input wire logic RESETN,
   input wire logic CE,
   input wire logic BUS_RESET_N,
   input wire logic [2:0] POWER_STATE,
   input wire logic SERIAL_INT_GPIO_MODE,
   input wire logic SERIAL_INT_GPIO_OUT,
   input wire logic SERIAL_INT_GPIO_OE,
   input wire logic SERIAL_INT_FLOAT_POS,
   input wire logic AUDIO_DATA_IN,
   input wire logic BOOT_ROM_SEL_IN,
   input wire logic [ACK_W-1:0] DMA_ACK_IN,
   input wire logic IO_READ_IN,
   input wire logic USB_REF_CLOCK_IN,
   input wire logic OSC_CLOCK_IN,
   input wire logic LID_SWITCH_IN,
   input wire logic BATTERY_LOW_N,
   input wire logic EXTERNAL_MGMT_INT_N,
   input wire logic RING_INDICATE_N,
   input wire logic THERMAL_ALARM_N,
   input wire logic DMA_REQUEST,
   input wire logic [OVC_W-1:0] USB_OVERCURRENT_N,
   input wire logic SERIALIZED_INTERRUPT_I,
   output logic SUSPEND_LEVEL_A_N,
   output logic SUSPEND_LEVEL_B_N,
   output logic SUSPEND_LEVEL_C_N,
   output logic SUSPEND_STATUS_N,
   output logic SUSPEND_CLOCK_OUT,
   output logic PROCESSOR_CLOCK_STOP_N,
   output logic PROCESSOR_CLOCK_STOP_OE,
   output logic BUS_CLOCK_STOP_N,
   output logic BUS_CLOCK_STOP_OE,
   output logic BUS_CLOCK_OUT,
   output logic AUDIO_LINK_DATA_OUT,
   output logic AUDIO_LINK_DATA_OE,
   output logic AUDIO_LINK_FRAME_SYNC,
   output logic SERIALIZED_INTERRUPT_O,
   output logic SERIALIZED_INTERRUPT_OE,
   output logic BOOT_ROM_SELECT_N,
   output logic BOOT_ROM_SELECT_OE,
   output logic [ACK_W-1:0] DMA_ACKNOWLEDGE_N,
   output logic DMA_ACKNOWLEDGE_OE,
   output logic IO_READ_STROBE_N,
   output logic IO_READ_STROBE_OE,
   output logic USB_PORT_ZERO_OE,
   output logic USB_PORT_ONE_OE,
   output logic USB_REF_CLOCK_SEEN,
   output logic OSC_CLOCK_SEEN,
   output logic [3:0] WAKE_INPUTS,
   output logic THERMAL_ALARM_SEEN,
   output logic DMA_REQUEST_SEEN,
   output logic [OVC_W-1:0] USB_OVERCURRENT_SEEN
);
   spsc_pkg::spsc_state_e st_q, st_d; // registered power state
   logic clk_div_run_sus; // suspend clock gate
   logic clk_div_run_bus; // bus clock gate
   logic gp_out, gp_oe, gp_mode; // held gpio pin state
   logic pos, ram_s, disk_s, rst_s; // state decodes

   // decode a raw code; illegal codes fall back to reset behaviour
   function automatic spsc_pkg::spsc_state_e decode_state(input logic [2:0] c);
      case (c)
         3'h1: decode_state = spsc_pkg::SPSC_RUN;
         3'h2: decode_state = spsc_pkg::SPSC_POS;
         3'h3: decode_state = spsc_pkg::SPSC_RAM;
         3'h4: decode_state = spsc_pkg::SPSC_DISK;
         default: decode_state = spsc_pkg::SPSC_RESET;
      endcase
   endfunction

   // next state: a single code steers all state-dependent pins together
   always_comb
   begin
      st_d = decode_state(POWER_STATE);
   end

   // state register, frozen when clock enable is low
   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
         st_q <= spsc_pkg::SPSC_RESET;
      else if (CE)
         st_q <= st_d;
   end

   assign rst_s = (st_q == spsc_pkg::SPSC_RESET);
   assign pos = (st_q == spsc_pkg::SPSC_POS);
   assign ram_s = (st_q == spsc_pkg::SPSC_RAM);
   assign disk_s = (st_q == spsc_pkg::SPSC_DISK);

   // gpio hold sits on the resume reset only; bus reset must not wipe it
   spsc_gpio_hold u_gpio (
      .clk(CLK),
      .rst_n(RESETN),
      .ce(CE),
      .gpio_mode(SERIAL_INT_GPIO_MODE),
      .gpio_out(SERIAL_INT_GPIO_OUT),
      .gpio_oe(SERIAL_INT_GPIO_OE),
      .pin_out(gp_out),
      .pin_oe(gp_oe),
      .pin_gpio(gp_mode)
   );

   assign clk_div_run_sus = !disk_s;
   // main well is down in disk suspend, so the bus clock parks there too
   assign clk_div_run_bus = !(pos || ram_s || disk_s);

   // suspend clock, stops low only in disk suspend
   spsc_clkdiv #(.HALF(spsc_pkg::SPSC_SUS_CLOCK_HALF)) u_suspend_clock_out (
      .clk(CLK),
      .rst_n(RESETN),
      .ce(CE),
      .run(clk_div_run_sus),
      .clk_out(SUSPEND_CLOCK_OUT)
   );

   // bus clock, parked low through pos and ram suspend
   spsc_clkdiv #(.HALF(spsc_pkg::SPSC_BUSCLK_HALF)) u_busclk (
      .clk(CLK),
      .rst_n(RESETN),
      .ce(CE),
      .run(clk_div_run_bus),
      .clk_out(BUS_CLOCK_OUT)
   );

   // suspend level outputs, active low
   assign SUSPEND_LEVEL_A_N = !(pos || ram_s || disk_s);
   assign SUSPEND_LEVEL_B_N = !(ram_s || disk_s);
   assign SUSPEND_LEVEL_C_N = !disk_s;
   assign SUSPEND_STATUS_N = !(rst_s || pos || ram_s || disk_s);

   // clock stop pins: isolation means driver off in ram suspend
   assign PROCESSOR_CLOCK_STOP_N = !pos;
   assign PROCESSOR_CLOCK_STOP_OE = !ram_s && !disk_s;
   assign BUS_CLOCK_STOP_N = !pos;
   assign BUS_CLOCK_STOP_OE = !ram_s && !disk_s;

   // audio link; data held low while the link is not in use
   assign AUDIO_LINK_DATA_OUT = (st_q == spsc_pkg::SPSC_RUN) ? AUDIO_DATA_IN : 1'b0;
   assign AUDIO_LINK_DATA_OE = !ram_s && !disk_s;
   assign AUDIO_LINK_FRAME_SYNC = 1'b0;

   // serial interrupt: gpio state, optionally floated in pos
   assign SERIALIZED_INTERRUPT_O = gp_out;
   assign SERIALIZED_INTERRUPT_OE = gp_oe && !ram_s && !disk_s
                                    && !(pos && SERIAL_INT_FLOAT_POS);

   // expansion bus strobes and selects; idle high outside run
   assign BOOT_ROM_SELECT_N = (st_q == spsc_pkg::SPSC_RUN) ? BOOT_ROM_SEL_IN : 1'b1;
   assign BOOT_ROM_SELECT_OE = !ram_s && !disk_s;
   assign DMA_ACKNOWLEDGE_N = (st_q == spsc_pkg::SPSC_RUN) ? DMA_ACK_IN : '1;
   assign DMA_ACKNOWLEDGE_OE = !ram_s && !disk_s;
   // strobe floats to its pull-up except in pos, where it is driven high
   assign IO_READ_STROBE_N = pos ? 1'b1 : IO_READ_IN;
   assign IO_READ_STROBE_OE = pos;

   // usb port is never driven by this block
   assign USB_PORT_ZERO_OE = 1'b0;
   assign USB_PORT_ONE_OE = 1'b0;

   // input isolation: main well inputs read inactive in ram and disk suspend (zero, thermal alarm one)
   assign USB_REF_CLOCK_SEEN = USB_REF_CLOCK_IN && !ram_s && !disk_s;
   assign OSC_CLOCK_SEEN = OSC_CLOCK_IN && !ram_s && !disk_s;
   assign THERMAL_ALARM_SEEN = THERMAL_ALARM_N || ram_s || disk_s;
   assign DMA_REQUEST_SEEN = DMA_REQUEST && !ram_s && !disk_s;
   // resume well inputs stay live in every state
   assign WAKE_INPUTS = {LID_SWITCH_IN, BATTERY_LOW_N,
                         EXTERNAL_MGMT_INT_N, RING_INDICATE_N};
   assign USB_OVERCURRENT_SEEN = USB_OVERCURRENT_N;

   // helper: run length of suspend clock low
   logic [7:0] sus_low_cnt_q;
   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
         sus_low_cnt_q <= '0;
      else if (CE)
         sus_low_cnt_q <= SUSPEND_CLOCK_OUT ? 8'h00 :
                          ((sus_low_cnt_q == 8'hff) ? 8'hff : sus_low_cnt_q + 8'h01);
   end

   property p_level_a;
      @(posedge CLK) disable iff (!RESETN)
      (pos || ram_s || disk_s) |-> !SUSPEND_LEVEL_A_N;
   endproperty
   a_level_a: assert property (p_level_a) else $error("level a not low in suspend");
   property p_level_b;
      @(posedge CLK) disable iff (!RESETN)
      pos |-> SUSPEND_LEVEL_B_N && !SUSPEND_LEVEL_A_N;
   endproperty
   a_level_b: assert property (p_level_b) else $error("level b wrong in pos");
   property p_level_c;
      @(posedge CLK) disable iff (!RESETN)
      ram_s |-> SUSPEND_LEVEL_C_N && !SUSPEND_LEVEL_B_N;
   endproperty
   a_level_c: assert property (p_level_c) else $error("level c wrong in ram");
   property p_status;
      @(posedge CLK) disable iff (!RESETN)
      (st_q == spsc_pkg::SPSC_RUN) |-> SUSPEND_STATUS_N;
   endproperty
   a_status: assert property (p_status) else $error("status low while running");
   property p_suspend_clock_out;
      @(posedge CLK) disable iff (!RESETN)
      (!disk_s && CE) [*8] |-> sus_low_cnt_q < 8'h10;
   endproperty
   a_suspend_clock_out: assert property (p_suspend_clock_out) else $error("suspend clock stalled");
   property p_cpustop;
      @(posedge CLK) disable iff (!RESETN)
      ram_s |-> !PROCESSOR_CLOCK_STOP_OE && !BUS_CLOCK_STOP_OE;
   endproperty
   a_cpustop: assert property (p_cpustop) else $error("stop pins driven in ram");
   property p_busclk;
      @(posedge CLK) disable iff (!RESETN)
      (pos && CE) ##1 (pos && CE) |-> !BUS_CLOCK_OUT;
   endproperty
   a_busclk: assert property (p_busclk) else $error("bus clock running in pos");
   property p_ioread;
      @(posedge CLK) disable iff (!RESETN)
      IO_READ_STROBE_OE |-> pos && IO_READ_STROBE_N;
   endproperty
   a_ioread: assert property (p_ioread) else $error("io read driven outside pos");
   property p_sync;
      @(posedge CLK) disable iff (!RESETN)
      !AUDIO_LINK_FRAME_SYNC && !(ram_s && AUDIO_LINK_DATA_OE);
   endproperty
   a_sync: assert property (p_sync) else $error("audio link wrong");

   // status goes low in every suspend
   property p_status_sus;
      @(posedge CLK) disable iff (!RESETN)
      (pos || ram_s || disk_s) |-> !SUSPEND_STATUS_N;
   endproperty
   a_status_sus: assert property (p_status_sus) else $error("status high in suspend");
   // reset state: status low, all levels high
   property p_reset_levels;
      @(posedge CLK) disable iff (!RESETN)
      rst_s |-> !SUSPEND_STATUS_N && SUSPEND_LEVEL_A_N && SUSPEND_LEVEL_B_N && SUSPEND_LEVEL_C_N;
   endproperty
   a_reset_levels: assert property (p_reset_levels) else $error("levels wrong in reset");
   // disk suspend drops level c and b
   property p_level_c_disk;
      @(posedge CLK) disable iff (!RESETN)
      disk_s |-> !SUSPEND_LEVEL_C_N && !SUSPEND_LEVEL_B_N;
   endproperty
   a_level_c_disk: assert property (p_level_c_disk) else $error("level c high in disk");
   // suspend clock parked one cycle into disk suspend
   property p_suspend_clock_out_disk;
      @(posedge CLK) disable iff (!RESETN)
      disk_s ##1 disk_s |-> !SUSPEND_CLOCK_OUT;
   endproperty
   a_suspend_clock_out_disk: assert property (p_suspend_clock_out_disk) else $error("suspend clock runs in disk");
   // both stop pins driven low in pos
   property p_stop_pos;
      @(posedge CLK) disable iff (!RESETN)
      pos |-> !PROCESSOR_CLOCK_STOP_N && !BUS_CLOCK_STOP_N
              && PROCESSOR_CLOCK_STOP_OE && BUS_CLOCK_STOP_OE;
   endproperty
   a_stop_pos: assert property (p_stop_pos) else $error("stop pins not low in pos");
   // stop pins high while reset or running
   property p_stop_idle;
      @(posedge CLK) disable iff (!RESETN)
      (rst_s || st_q == spsc_pkg::SPSC_RUN) |-> PROCESSOR_CLOCK_STOP_N && BUS_CLOCK_STOP_N;
   endproperty
   a_stop_idle: assert property (p_stop_idle) else $error("stop pin low while running");
   // audio data driven low in pos
   property p_audio_pos;
      @(posedge CLK) disable iff (!RESETN)
      pos |-> AUDIO_LINK_DATA_OE && !AUDIO_LINK_DATA_OUT;
   endproperty
   a_audio_pos: assert property (p_audio_pos) else $error("audio data not low in pos");
   // audio data released in ram suspend
   property p_audio_ram;
      @(posedge CLK) disable iff (!RESETN)
      ram_s |-> !AUDIO_LINK_DATA_OE;
   endproperty
   a_audio_ram: assert property (p_audio_ram) else $error("audio data driven in ram");
   // serial interrupt pin floats in ram suspend
   property p_serial_int;
      @(posedge CLK) disable iff (!RESETN)
      ram_s |-> !SERIALIZED_INTERRUPT_OE;
   endproperty
   a_serial_int: assert property (p_serial_int) else $error("serial interrupt driven in ram");
   // boot select driven high in reset and pos
   property p_boot_sel;
      @(posedge CLK) disable iff (!RESETN)
      (rst_s || pos) |-> BOOT_ROM_SELECT_N && BOOT_ROM_SELECT_OE;
   endproperty
   a_boot_sel: assert property (p_boot_sel) else $error("boot select not high");
   // acknowledges driven high in reset and pos, released in ram
   property p_dma_ack;
      @(posedge CLK) disable iff (!RESETN)
      ((rst_s || pos) |-> (&DMA_ACKNOWLEDGE_N) && DMA_ACKNOWLEDGE_OE) and (ram_s |-> !DMA_ACKNOWLEDGE_OE);
   endproperty
   a_dma_ack: assert property (p_dma_ack) else $error("dma acknowledge wrong");
   // clock inputs masked once the main well sleeps
   property p_clk_iso;
      @(posedge CLK) disable iff (!RESETN)
      (ram_s || disk_s) |-> !USB_REF_CLOCK_SEEN && !OSC_CLOCK_SEEN;
   endproperty
   a_clk_iso: assert property (p_clk_iso) else $error("clock input seen in suspend");
   // thermal alarm reads inactive in ram suspend
   property p_thermal;
      @(posedge CLK) disable iff (!RESETN)
      ram_s |-> THERMAL_ALARM_SEEN;
   endproperty
   a_thermal: assert property (p_thermal) else $error("thermal alarm seen in ram");
   // dma request masked in ram suspend
   property p_dma_req;
      @(posedge CLK) disable iff (!RESETN)
      ram_s |-> !DMA_REQUEST_SEEN;
   endproperty
   a_dma_req: assert property (p_dma_req) else $error("dma request seen in ram");
   // bus clock parked in ram suspend
   property p_busclk_ram;
      @(posedge CLK) disable iff (!RESETN)
      ram_s ##1 ram_s |-> !BUS_CLOCK_OUT;
   endproperty
   a_busclk_ram: assert property (p_busclk_ram) else $error("bus clock running in ram");
   // clock enable low freezes the state register
   property p_freeze;
      @(posedge CLK) disable iff (!RESETN)
      !CE |=> $stable(st_q);
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved with enable low");
   // a pos code is taken at the next enabled edge
   property p_take_pos;
      @(posedge CLK) disable iff (!RESETN)
      (CE && POWER_STATE == 3'h2) |=> pos;
   endproperty
   a_take_pos: assert property (p_take_pos) else $error("pos code not taken");

   c_pos: cover property (@(posedge CLK) disable iff (!RESETN) pos);
   c_ram: cover property (@(posedge CLK) disable iff (!RESETN) pos ##1 ram_s);
   c_disk: cover property (@(posedge CLK) disable iff (!RESETN) disk_s);
   c_disk_exit: cover property (@(posedge CLK) disable iff (!RESETN) disk_s ##1 !disk_s);
   c_freeze: cover property (@(posedge CLK) disable iff (!RESETN) !CE ##1 !CE);
endmodule // spsc_top

// [tb/spsc_board_model.sv]
`timescale 1ns/100ps
// board oscillators and overcurrent sense feeding the block
module spsc_board_model (
   input wire logic CLK,
   output logic USB_REF_CLOCK_IN,
   output logic OSC_CLOCK_IN,
   output logic [1:0] USB_OVERCURRENT_N
);
   // divider for slow board clocks
   logic [5:0] cnt_q = 6'h00;
   // oscillators run free; slow so level checks see settled pins
   always @(posedge CLK)
   begin
      cnt_q <= cnt_q + 6'h01;
      USB_REF_CLOCK_IN <= cnt_q[2];
      OSC_CLOCK_IN <= cnt_q[3];
      USB_OVERCURRENT_N <= cnt_q[5:4];
   end
   // known pin levels at time zero
   initial
   begin
      USB_REF_CLOCK_IN = 1'b0;
      OSC_CLOCK_IN = 1'b0;
      USB_OVERCURRENT_N = 2'h3;
   end
endmodule // spsc_board_model

// [tb/suspend_pin_state_control_tb_top.sv]
`timescale 1ns/100ps
// power state pin bench
module suspend_pin_state_control_tb_top;
   logic clk = 1'b0, rstn = 1'b0, ce = 1'b1, brst_n = 1'b1, gm = 1'b0, go = 1'b0, ge = 1'b0;
   logic sfp = 1'b0, adi = 1'b0, bri = 1'b1, iori = 1'b1, lid_switch_in = 1'b0, bat_n = 1'b1;
   logic exs_n = 1'b1, ring_n = 1'b1, thr_n = 1'b1, drq = 1'b0;
   logic [2:0] ps = 3'h0;
   logic [3:0] dki = 4'hf;
   logic urc, osc, a_n, b_n, c_n, st_n, sclk, pcs_n, pcs_oe, bcs_n, bcs_oe, bclk, ad, ad_oe;
   logic afs, si_o, si_oe, br_n, br_oe, dk_oe, rd_n, rd_oe, u0_oe, u1_oe, urc_s, osc_s;
   logic thr_s, drq_s, sv_o, sv_oe;
   logic [3:0] dk_n, wake;
   logic [1:0] oc_n, oc_s;
   int fails = 0, tests_run = 0;
   // 125 MHz clock
   always #4 clk = ~clk;
   spsc_board_model board (.CLK(clk), .USB_REF_CLOCK_IN(urc), .OSC_CLOCK_IN(osc),
      .USB_OVERCURRENT_N(oc_n));
   spsc_top dut (.CLK(clk), .RESETN(rstn), .CE(ce), .BUS_RESET_N(brst_n), .POWER_STATE(ps),
      .SERIAL_INT_GPIO_MODE(gm), .SERIAL_INT_GPIO_OUT(go), .SERIAL_INT_GPIO_OE(ge),
      .SERIAL_INT_FLOAT_POS(sfp),
      .AUDIO_DATA_IN(adi), .BOOT_ROM_SEL_IN(bri), .DMA_ACK_IN(dki), .IO_READ_IN(iori),
      .USB_REF_CLOCK_IN(urc), .OSC_CLOCK_IN(osc), .LID_SWITCH_IN(lid_switch_in), .BATTERY_LOW_N(bat_n),
      .EXTERNAL_MGMT_INT_N(exs_n), .RING_INDICATE_N(ring_n), .THERMAL_ALARM_N(thr_n),
      .DMA_REQUEST(drq), .USB_OVERCURRENT_N(oc_n), .SERIALIZED_INTERRUPT_I(1'b0),
      .SUSPEND_LEVEL_A_N(a_n), .SUSPEND_LEVEL_B_N(b_n), .SUSPEND_LEVEL_C_N(c_n),
      .SUSPEND_STATUS_N(st_n), .SUSPEND_CLOCK_OUT(sclk), .PROCESSOR_CLOCK_STOP_N(pcs_n),
      .PROCESSOR_CLOCK_STOP_OE(pcs_oe), .BUS_CLOCK_STOP_N(bcs_n), .BUS_CLOCK_STOP_OE(bcs_oe),
      .BUS_CLOCK_OUT(bclk), .AUDIO_LINK_DATA_OUT(ad), .AUDIO_LINK_DATA_OE(ad_oe),
      .AUDIO_LINK_FRAME_SYNC(afs), .SERIALIZED_INTERRUPT_O(si_o), .SERIALIZED_INTERRUPT_OE(si_oe),
      .BOOT_ROM_SELECT_N(br_n), .BOOT_ROM_SELECT_OE(br_oe), .DMA_ACKNOWLEDGE_N(dk_n),
      .DMA_ACKNOWLEDGE_OE(dk_oe), .IO_READ_STROBE_N(rd_n), .IO_READ_STROBE_OE(rd_oe),
      .USB_PORT_ZERO_OE(u0_oe), .USB_PORT_ONE_OE(u1_oe), .USB_REF_CLOCK_SEEN(urc_s),
      .OSC_CLOCK_SEEN(osc_s), .WAKE_INPUTS(wake), .THERMAL_ALARM_SEEN(thr_s),
      .DMA_REQUEST_SEEN(drq_s), .USB_OVERCURRENT_SEEN(oc_s));
   // value compare, four-state exact
   task automatic chk(input logic [3:0] g, input logic [3:0] x);
      tests_run++;
      if (g !== x)
      begin
         fails++;
         $display("unexpected at %0t: got %h expected %h", $time, g, x);
      end
   endtask
   // illegal codes behave as the reset state
   function automatic int eff(input logic [2:0] s);
      return (s > 3'h4) ? 0 : int'(s);
   endfunction
   // static pin levels for effective state e
   task automatic check(input int e);
      chk(a_n, e < 2);
      chk(b_n, e < 3);
      chk(c_n, e != 4);
      chk(st_n, e == 1);
      chk(pcs_oe, e < 3);
      if (e < 3) chk(pcs_n, e < 2);
      chk(bcs_oe, e < 3);
      if (e < 3) chk(bcs_n, e < 2);
      chk(ad_oe, e < 3);
      if (e < 3) chk(ad, (e == 1) ? adi : 1'b0);
      if (e < 4) chk(afs, 1'b0);
      if (e == 3 || (e == 2 && sfp)) chk(si_oe, 1'b0);
      chk(br_oe, e < 3);
      if (e < 3) chk(br_n, (e == 1) ? bri : 1'b1);
      chk(dk_oe, e < 3);
      if (e < 3) chk(dk_n, (e == 1) ? dki : 4'hf);
      if (e != 1) chk(rd_oe, e == 2);
      if (e == 2) chk(rd_n, 1'b1);
      chk({urc_s, osc_s}, (e < 3) ? {urc, osc} : 2'h0);
      chk(wake, {lid_switch_in, bat_n, exs_n, ring_n});
      if (e < 4) chk(thr_s, (e < 3) ? thr_n : 1'b1);
      chk(drq_s, (e < 3) & drq);
      chk({u0_oe, u1_oe}, 2'h0);
      chk(oc_s, oc_n);
   endtask
   // new state with random pin inputs, then levels and clock activity
   task automatic apply(input logic [2:0] s);
      int e, sc, sh, bc, bh;
      logic ls, lb;
      e = eff(s);
      sc = 0;
      sh = 0;
      bc = 0;
      bh = 0;
      @(posedge clk);
      ps <= s;
      {sfp, adi, bri, iori, lid_switch_in, bat_n, exs_n, ring_n, thr_n, drq} <= 10'($urandom);
      dki <= 4'($urandom);
      @(posedge clk);
      @(negedge clk);
      check(e);
      ls = sclk;
      lb = bclk;
      repeat (12)
      begin
         @(negedge clk);
         sc += int'(sclk !== ls);
         sh += int'(sclk);
         bc += int'(bclk !== lb);
         bh += int'(bclk);
         ls = sclk;
         lb = bclk;
      end
      chk((e == 4) ? (sh == 0) : (sc >= 2), 1'b1);
      chk((e < 2) ? (bc >= 2) : (bh == 0), 1'b1);
   endtask
   // counts and verdict
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // watchdog well beyond the expected run
   initial
   begin
      #200000;
      fails++;
      finish_test();
   end
   // main sequence
   initial
   begin
      void'($urandom(32'h430366c0));
      repeat (4) @(posedge clk);
      @(negedge clk);
      check(0);
      chk(si_oe, spsc_pkg::SPSC_GPIO_RST_OE);
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      $display("test reset done");
      for (int i = 0; i < 8; i++) apply(3'(i));
      $display("test all codes done");
      repeat (40) apply(3'($urandom_range(7, 0)));
      $display("test random done");
      // gpio state must survive a bus reset alone
      @(posedge clk);
      // gpio mode on, driving high, so the pin state is worth keeping
      {gm, go, ge} <= 3'h7;
      apply(3'h1);
      sv_o = si_o;
      sv_oe = si_oe;
      @(posedge clk);
      brst_n <= 1'b0;
      repeat (3) @(posedge clk);
      brst_n <= 1'b1;
      @(negedge clk);
      chk({si_o, si_oe}, {sv_o, sv_oe});
      // resume reset in mid-run brings gpio back to functional state
      @(posedge clk);
      rstn <= 1'b0;
      @(negedge clk);
      check(0);
      chk(si_oe, spsc_pkg::SPSC_GPIO_RST_OE);
      @(posedge clk);
      rstn <= 1'b1;
      apply(3'h2);
      $display("test resets done");
      // enable low: a new code must not be taken
      @(posedge clk);
      ce <= 1'b0;
      ps <= 3'h4;
      repeat (3) @(posedge clk);
      @(negedge clk);
      check(2);
      chk(c_n, 1'b1);
      @(posedge clk);
      ce <= 1'b1;
      apply(3'h4);
      $display("test freeze done");
      finish_test();
   end
endmodule // suspend_pin_state_control_tb_top
